//--- shared/tsw_regs.svh
// register offsets, field positions, reset values and counts of the time-slot switch core
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH

`define TSW_OFF_CTRL 12'h000
`define TSW_OFF_MODE 12'h004
`define TSW_OFF_PAIRS 12'h008
`define TSW_OFF_STATUS 12'h00C
`define TSW_WIN_SEL 4'h1

`define TSW_CTRL_RST 8'h00
`define TSW_MODE_RST 8'h00
`define TSW_PAIRS_RST 8'h32

`define TSW_AREA_CML 2'h0
`define TSW_AREA_CMH 2'h1
`define TSW_AREA_DM 2'h2

`define TSW_RATE_2M 2'h0
`define TSW_RATE_4M 2'h1
`define TSW_RATE_8M 2'h2

`define TSW_DM_DEPTH 512
`define TSW_CH_BITS_BASE 5
`define TSW_FRAME_BITS_BASE 11'h100
`define TSW_LAST_BIT 3'h7
`define TSW_IDLE_RUN 3'h4
`define TSW_SHARED_IN 14
`define TSW_LAST_WRITE 4'hF
`define TSW_LAST_FETCH 3'h7
`define TSW_INIT_LAST 10'h3FF

`endif

//--- shared/tsw_pkg.sv
// types of the time-slot switch core
`default_nettype none
package tsw_pkg;
    typedef enum logic [1:0] {TSW_CFG_8X8, TSW_CFG_16X8, TSW_CFG_PAIRS, TSW_CFG_SPARE} tsw_cfg_t;
    typedef enum logic [1:0] {TSW_INIT, TSW_IDLE, TSW_WRITE, TSW_FETCH} tsw_seq_t;
    typedef struct packed {
        logic [2:0] spare;
        logic src_hi;
        logic cst;
        logic oe;
        logic cdly;
        logic msg;
    } tsw_cmh_t;
    typedef struct packed {
        logic [7:0] data;
        logic oe;
        logic cst;
    } tsw_slot_t;
endpackage
`default_nettype wire

//--- rtl/tsw_core.sv
// time-slot interchange core with APB register and memory access
`include "tsw_regs.svh"
`default_nettype none
module tsw_core
    import tsw_pkg::*;
#(
    parameter int DM_DEPTH = `TSW_DM_DEPTH
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial backbone
    input wire logic serial_clk,
    input wire logic frame_sync_input,
    input wire logic [15:0] serial_in,
    output logic [7:0] serial_out,
    output logic [7:0] serial_oe,
    input wire logic shared_stream_in,
    output logic shared_stream_out,
    output logic shared_stream_oe,
    output logic control_serial_out,
    // pins
    input wire logic global_output_drive_gate,
    input wire logic host_bus_select_pin
);
    if (DM_DEPTH != `TSW_DM_DEPTH) begin : g_chk
        $error("tsw_core: address layout serves only the documented depth");
    end

    function automatic logic [6:0] ch_mask(input logic [1:0] r);
        case (r)
            `TSW_RATE_2M: ch_mask = 7'h1F;
            `TSW_RATE_4M: ch_mask = 7'h3F;
            default: ch_mask = 7'h7F;
        endcase
    endfunction

    function automatic logic [8:0] mem_idx(input logic [3:0] s, input logic [6:0] ch,
                                           input logic [1:0] r);
        logic [15:0] t;
        t = ({12'h000, s} << (`TSW_CH_BITS_BASE + r)) | {9'h000, ch & ch_mask(r)};
        mem_idx = t[8:0];
    endfunction

    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] pairs;
    logic [1:0] rate;
    tsw_cfg_t cfg;
    logic host_mux;
    logic [7:0] dm_mem [0:2*DM_DEPTH-1];
    logic [7:0] cml_mem [0:DM_DEPTH-1];
    logic [7:0] cmh_mem [0:DM_DEPTH-1];

    assign rate = (mode[1:0] == 2'h3) ? `TSW_RATE_8M : mode[1:0];
    assign cfg = tsw_cfg_t'(mode[3:2]);
    assign host_mux = host_bus_select_pin;

    // input stream and output stream counts for the selected configuration
    logic [4:0] n_in;
    logic [3:0] n_out;
    always_comb begin
        if (cfg == TSW_CFG_16X8) begin
            n_in = host_mux ? 5'h10 : 5'h08;
            n_out = 4'h8;
        end else if (cfg == TSW_CFG_PAIRS) begin
            n_in = 5'h04;
            n_out = 4'h4;
        end else begin
            n_in = (rate == `TSW_RATE_8M) ? 5'h04 : 5'h08;
            n_out = 4'h8 >> rate;
        end
    end

    function automatic logic [3:0] in_phys(input logic [3:0] s, input tsw_cfg_t c,
                                           input logic [7:0] pr);
        in_phys = s;
        if (c == TSW_CFG_PAIRS) begin
            case (s[1:0])
                2'h2: in_phys = pr[3:0];
                2'h3: in_phys = pr[7:4];
                default: in_phys = s;
            endcase
        end
    endfunction

    // ---------------- serial timing ----------------
    logic sclk_d;
    logic tick;
    logic fs_idle;
    logic fs_prev;
    logic fs_act_prev;
    logic [2:0] fs_run;
    logic fs_start;
    logic frame_seen;
    logic [9:0] bit_cnt;
    logic [9:0] cur_bit;
    logic [6:0] cur_ch;
    logic [10:0] frame_bits;
    logic cur_bank;
    logic ch_end;
    logic ch_begin;

    assign tick = serial_clk & ~sclk_d;
    assign fs_start = tick & (frame_sync_input != fs_idle) & ~fs_act_prev;
    assign cur_bit = fs_start ? 10'h000 : bit_cnt;
    assign cur_ch = cur_bit[9:3] & ch_mask(rate);
    assign frame_bits = `TSW_FRAME_BITS_BASE << rate;
    assign ch_end = tick & (cur_bit[2:0] == `TSW_LAST_BIT);
    assign ch_begin = tick & (cur_bit[2:0] == 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // starts high so a bit clock already high at release is not taken as an edge
            sclk_d <= 1'b1;
        end else begin
            sclk_d <= serial_clk;
        end
    end

    // idle level is the one that persists; a pulse is any departure from it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_idle <= 1'b1;
            fs_prev <= 1'b1;
            fs_run <= 3'h0;
            fs_act_prev <= 1'b0;
        end else if (tick) begin
            fs_prev <= frame_sync_input;
            fs_act_prev <= frame_sync_input != fs_idle;
            if (frame_sync_input != fs_prev) begin
                fs_run <= 3'h0;
            end else if (fs_run != `TSW_IDLE_RUN) begin
                fs_run <= fs_run + 3'h1;
            end else begin
                fs_idle <= frame_sync_input;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 10'h000;
            frame_seen <= 1'b0;
        end else if (tick) begin
            if (fs_start) begin
                frame_seen <= 1'b1;
            end
            if ({1'b0, cur_bit} == frame_bits - 11'h001) begin
                bit_cnt <= 10'h000;
            end else begin
                bit_cnt <= cur_bit + 10'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_bank <= 1'b0;
        end else if (tick && cur_bit == 10'h000) begin
            cur_bank <= ~cur_bank;
        end
    end

    // ---------------- receive side ----------------
    logic [15:0] in_bits;
    logic [7:0] sh_in [0:15];
    logic [7:0] hold [0:15];
    logic [6:0] hold_ch;
    logic hold_bank;

    always_comb begin
        in_bits = serial_in;
        in_bits[`TSW_SHARED_IN] = 1'b0;
        if (cfg == TSW_CFG_16X8 && host_mux) begin
            in_bits[`TSW_SHARED_IN] = shared_stream_in;
        end
    end

    always_ff @(posedge pclk) begin
        if (tick) begin
            for (int p = 0; p < 16; p++) begin
                sh_in[p] <= {sh_in[p][6:0], in_bits[p]};
                if (ch_end) begin
                    hold[p] <= {sh_in[p][6:0], in_bits[p]};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ch <= 7'h00;
            hold_bank <= 1'b0;
        end else if (ch_end) begin
            hold_ch <= cur_ch;
            hold_bank <= cur_bank;
        end
    end

    // ---------------- memory sequencer ----------------
    tsw_seq_t seq;
    logic [9:0] seq_idx;
    logic write_pend;
    logic fetch_pend;
    logic [6:0] fetch_ch;
    logic [6:0] fetch_in_ch;
    logic fetch_bank;
    logic write_done;
    logic fetch_done;

    assign write_done = (seq == TSW_WRITE) && (seq_idx[3:0] == `TSW_LAST_WRITE);
    assign fetch_done = (seq == TSW_FETCH) && (seq_idx[2:0] == `TSW_LAST_FETCH);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq <= TSW_INIT;
            seq_idx <= 10'h000;
        end else begin
            case (seq)
                TSW_INIT: begin
                    seq_idx <= seq_idx + 10'h001;
                    if (seq_idx == `TSW_INIT_LAST) begin
                        seq <= TSW_IDLE;
                    end
                end
                TSW_IDLE: begin
                    seq_idx <= 10'h000;
                    if (write_pend) begin
                        seq <= TSW_WRITE;
                    end else if (fetch_pend) begin
                        seq <= TSW_FETCH;
                    end
                end
                TSW_WRITE, TSW_FETCH: begin
                    seq_idx <= seq_idx + 10'h001;
                    if (write_done || fetch_done) begin
                        seq <= TSW_IDLE;
                    end
                end
                default: seq <= TSW_IDLE;
            endcase
        end
    end

    // a new request set in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_pend <= 1'b0;
            fetch_pend <= 1'b0;
        end else begin
            write_pend <= ch_end | (write_pend & ~write_done);
            fetch_pend <= ch_begin | (fetch_pend & ~fetch_done);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_ch <= 7'h00;
            fetch_in_ch <= 7'h00;
            fetch_bank <= 1'b0;
        end else if (ch_begin) begin
            fetch_ch <= (cur_ch + 7'h01) & ch_mask(rate);
            fetch_in_ch <= cur_ch;
            fetch_bank <= (cur_bit == 10'h000) ? ~cur_bank : cur_bank;
        end
    end

    always_ff @(posedge pclk) begin
        if (seq == TSW_INIT) begin
            dm_mem[seq_idx] <= 8'h00;
        end else if (seq == TSW_WRITE && {1'b0, seq_idx[3:0]} < n_in) begin
            dm_mem[{hold_bank, mem_idx(seq_idx[3:0], hold_ch, rate)}] <=
                hold[in_phys(seq_idx[3:0], cfg, pairs)];
        end
    end

    // ---------------- fetch of the next channel ----------------
    tsw_slot_t nxt [0:7];
    tsw_slot_t fetched;
    tsw_cmh_t f_cmh;
    logic [7:0] f_cml;
    logic [8:0] f_src;
    logic f_prev;

    always_comb begin
        f_cmh = tsw_cmh_t'(cmh_mem[mem_idx({1'b0, seq_idx[2:0]}, fetch_ch, rate)]);
        f_cml = cml_mem[mem_idx({1'b0, seq_idx[2:0]}, fetch_ch, rate)];
        f_src = {f_cmh.src_hi, f_cml};
        // constant delay reads last frame's bank except in the 16x8 configuration; variable reads the newest copy
        f_prev = (f_cmh.cdly && cfg != TSW_CFG_16X8) ||
                 ((f_src[6:0] & ch_mask(rate)) >= fetch_in_ch);
        fetched.data = f_cmh.msg ? f_cml : dm_mem[{fetch_bank ^ f_prev, f_src}];
        fetched.oe = f_cmh.oe && ({1'b0, seq_idx[2:0]} < n_out);
        fetched.cst = f_cmh.cst;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int o = 0; o < 8; o++) begin
                nxt[o] <= '0;
            end
        end else if (seq == TSW_FETCH) begin
            nxt[seq_idx[2:0]] <= fetched;
        end
    end

    // ---------------- transmit side ----------------
    logic [7:0] sh_out [0:7];
    logic [7:0] cur_oe;
    logic [7:0] cur_cst;
    logic [7:0] lbit;
    logic [7:0] nxt_cst;

    always_comb begin
        for (int o = 0; o < 8; o++) begin
            lbit[o] = ch_begin ? nxt[o].data[7] : sh_out[o][7];
            nxt_cst[o] = nxt[o].cst;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_oe <= 8'h00;
            cur_cst <= 8'h00;
            for (int o = 0; o < 8; o++) begin
                sh_out[o] <= 8'h00;
            end
        end else if (tick) begin
            for (int o = 0; o < 8; o++) begin
                if (ch_begin) begin
                    sh_out[o] <= {nxt[o].data[6:0], 1'b0};
                    cur_oe[o] <= nxt[o].oe;
                    cur_cst[o] <= nxt[o].cst;
                end else begin
                    sh_out[o] <= {sh_out[o][6:0], 1'b0};
                end
            end
        end
    end

    // physical pin p is fed by logical output stream src; index 8 is the shared pin
    logic [8:0] pin_valid;
    logic [2:0] pin_src [0:8];
    always_comb begin
        for (int p = 0; p < 9; p++) begin
            pin_src[p] = p[2:0];
            pin_valid[p] = (p < 8) && (cfg != TSW_CFG_PAIRS);
            if (cfg == TSW_CFG_PAIRS) begin
                if (p < 2) begin
                    pin_src[p] = p[2:0];
                    pin_valid[p] = 1'b1;
                end else if (p[3:0] == pairs[3:0]) begin
                    pin_src[p] = 3'h2;
                    pin_valid[p] = (p < 8) || host_mux;
                end else if (p[3:0] == pairs[7:4]) begin
                    pin_src[p] = 3'h3;
                    pin_valid[p] = (p < 8) || host_mux;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out <= 8'h00;
            serial_oe <= 8'h00;
            shared_stream_out <= 1'b0;
            shared_stream_oe <= 1'b0;
            control_serial_out <= 1'b0;
        end else begin
            for (int p = 0; p < 8; p++) begin
                if (tick) begin
                    serial_out[p] <= lbit[pin_src[p]];
                end
                serial_oe[p] <= global_output_drive_gate & pin_valid[p] &
                                cur_oe[pin_src[p]];
            end
            if (tick) begin
                shared_stream_out <= lbit[pin_src[8]];
                control_serial_out <= ch_begin ? nxt_cst[0] : cur_cst[cur_bit[2:0]];
            end
            shared_stream_oe <= global_output_drive_gate & pin_valid[8] &
                                cur_oe[pin_src[8]];
        end
    end

    // ---------------- APB registers and memory window ----------------
    logic acc;
    logic wr;
    logic is_win;
    logic mapped;
    logic [8:0] win_idx;
    logic [31:0] rd_val;

    assign acc = psel & penable & ~pready;
    assign wr = psel & penable & pready & pwrite;
    assign is_win = paddr[11:8] == `TSW_WIN_SEL;
    assign win_idx = {ctrl[2:0], paddr[7:2]};
    assign mapped = is_win || paddr == `TSW_OFF_CTRL || paddr == `TSW_OFF_MODE ||
                    paddr == `TSW_OFF_PAIRS || paddr == `TSW_OFF_STATUS;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_win) begin
            case (ctrl[5:4])
                `TSW_AREA_CML: rd_val[7:0] = cml_mem[win_idx];
                `TSW_AREA_CMH: rd_val[7:0] = cmh_mem[win_idx];
                `TSW_AREA_DM: rd_val[7:0] = dm_mem[{cur_bank, win_idx}];
                default: rd_val = 32'h0000_0000;
            endcase
        end else if (paddr == `TSW_OFF_CTRL) begin
            rd_val[7:0] = ctrl;
        end else if (paddr == `TSW_OFF_MODE) begin
            rd_val[7:0] = mode;
        end else if (paddr == `TSW_OFF_PAIRS) begin
            rd_val[7:0] = pairs;
        end else if (paddr == `TSW_OFF_STATUS) begin
            rd_val[3:0] = {seq != TSW_INIT, frame_seen, host_mux, ~fs_idle};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc;
            pslverr <= acc & ~mapped;
            if (acc && !pwrite) begin
                prdata <= rd_val;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `TSW_CTRL_RST;
            mode <= `TSW_MODE_RST;
            pairs <= `TSW_PAIRS_RST;
        end else if (wr) begin
            if (paddr == `TSW_OFF_CTRL) begin
                ctrl <= pwdata[7:0];
            end
            if (paddr == `TSW_OFF_MODE) begin
                mode <= pwdata[7:0];
            end
            if (paddr == `TSW_OFF_PAIRS) begin
                pairs <= pwdata[7:0];
            end
        end
    end

    // the clear sweep owns the port; host writes during it are dropped
    always_ff @(posedge pclk) begin
        if (seq == TSW_INIT) begin
            cml_mem[seq_idx[8:0]] <= 8'h00;
            cmh_mem[seq_idx[8:0]] <= 8'h00;
        end else if (wr && is_win) begin
            if (ctrl[5:4] == `TSW_AREA_CML) begin
                cml_mem[win_idx] <= pwdata[7:0];
            end
            if (ctrl[5:4] == `TSW_AREA_CMH) begin
                cmh_mem[win_idx] <= pwdata[7:0];
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/tsw_core_sva.sv
// port checker for the time-slot switch core
`default_nettype none
module tsw_core_chk (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial side
    input wire logic serial_clk,
    input wire logic [7:0] serial_out,
    input wire logic [7:0] serial_oe,
    input wire logic shared_stream_oe,
    input wire logic control_serial_out,
    input wire logic global_output_drive_gate
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_hold;
        pready |-> psel && penable;
    endproperty
    a_hold: assert property (p_hold) else $error("pready outside access");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_upper;
        pready && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_unmapped;
        pready && pslverr && !pwrite |-> prdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("refused read not zero");
    property p_gate;
        !global_output_drive_gate |=> serial_oe == 8'h00 && !shared_stream_oe;
    endproperty
    a_gate: assert property (p_gate) else $error("driver on with gate low");
    // enables may only move near a bit tick or after the gate moves
    property p_oe;
        (!serial_clk && $stable(global_output_drive_gate)) [*2] |-> $stable(serial_oe);
    endproperty
    a_oe: assert property (p_oe) else $error("enable moved mid bit");
    property p_out;
        (!serial_clk) [*2] |-> $stable(serial_out);
    endproperty
    a_out: assert property (p_out) else $error("data moved mid bit");
    property p_cst;
        (!serial_clk) [*2] |-> $stable(control_serial_out);
    endproperty
    a_cst: assert property (p_cst) else $error("control bit moved mid bit");
endmodule
bind tsw_core tsw_core_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .serial_clk, .serial_out, .serial_oe, .shared_stream_oe,
    .control_serial_out, .global_output_drive_gate);
`default_nettype wire

//--- verif/tsw_bb_model.sv
// backbone model: free-running bit clock, frame pulse and input streams
`default_nettype none
module tsw_bb_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // backbone
    output logic serial_clk,
    output logic frame_sync_input,
    output logic [15:0] serial_in,
    output logic shared_stream_in,
    // bench view
    output logic [4:0] phase,
    output logic [7:0] bit_pos
);
    timeunit 1ns;
    timeprecision 1ps;
    function automatic logic [7:0] pat(input int s, input logic [4:0] c);
        return {s[3:0], c[3:0]} ^ 8'h5A;
    endfunction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 5'h00;
            bit_pos <= 8'hFF;
        end else begin
            phase <= phase + 5'h01;
            if (phase == 5'h0F) begin
                bit_pos <= bit_pos + 8'h01;
            end
        end
    end
    // 32 pclk per bit stays inside the pclk/25 limit; data moves on the falling edge
    assign serial_clk = !phase[4];
    assign frame_sync_input = (bit_pos != 8'h00);
    always_comb begin
        for (int s = 0; s < 16; s++) begin
            serial_in[s] = |(pat(s, bit_pos[7:3]) & (8'h80 >> bit_pos[2:0]));
        end
        shared_stream_in = serial_in[14];
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the time-slot switch core
`include "tsw_regs.svh"
`default_nettype none
module tb_top import tsw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic e; logic [31:0] d; logic [31:0] m;} tsw_note_t;
    localparam int ST [6] = '{0, 8, 1, 2, 0, 3};
    localparam int CH [6] = '{1, 1, 2, 2, 3, 4};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h8C9F6069;
    logic pready, pslverr, serial_clk, frame_sync_input, shared_stream_in, control_serial_out;
    logic [15:0] serial_in;
    logic [7:0] serial_out, serial_oe, bit_pos, msg;
    logic [7:0] sh [6];
    logic ok [6];
    logic [4:0] phase;
    logic global_output_drive_gate = 1, host_bus_select_pin = 1, watch = 0;
    int n_mismatch = 0, checks = 0;
    tsw_note_t rq[$];
    logic [8:0] sq[$];
    tsw_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .serial_clk, .frame_sync_input, .serial_in, .serial_out,
        .serial_oe, .shared_stream_in, .shared_stream_out(), .shared_stream_oe(),
        .control_serial_out, .global_output_drive_gate, .host_bus_select_pin);
    tsw_bb_model bb (.pclk, .presetn, .serial_clk, .frame_sync_input, .serial_in,
        .shared_stream_in, .phase, .bit_pos);
    always #2 pclk = ~pclk;
    function automatic logic [7:0] pat(input logic [3:0] s, input logic [3:0] c);
        return {s, c} ^ 8'h5A;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task finish_test;
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task bad(input logic [31:0] g, input logic [31:0] x);
        n_mismatch++;
        $display("unexpected at %0t: got %h expected %h", $time, g, x);
    endtask
    task cmp_rd(input tsw_note_t n, input logic e, input logic [31:0] d);
        checks++;
        if (e !== n.e || ((d ^ n.d) & n.m) !== 32'h0) bad({e, d[30:0]}, {n.e, n.d[30:0]});
    endtask
    task cmp_byte(input logic [8:0] x, input logic [8:0] g);
        checks++;
        if (g[8] !== x[8] || (x[8] && g[7:0] !== x[7:0])) bad({23'h0, g}, {23'h0, x});
    endtask
    // one apb transfer; the expectation is queued before the request goes out
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed,
            input logic [31:0] em, input logic ee);
        int n;
        rq.push_back('{ee, ed, em});
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel <= 0;
        penable <= 0;
        if (n >= 16) begin
            bad(32'h0, 32'h1);
            finish_test;
        end
    endtask
    task mem(input logic w, input logic [1:0] ar, input logic [8:0] ix, input logic [7:0] v);
        apb(1, `TSW_OFF_CTRL, {26'h0, ar, 1'b0, ix[8:6]}, 32'h0, 32'h0, 0);
        apb(w, 12'h100 | {4'h0, ix[5:0], 2'b00}, {24'h0, v}, {24'h0, v}, w ? 0 : 32'hFF, 0);
    endtask
    task wait_pos(input logic [7:0] p);
        for (int k = 0; k < 20000 && bit_pos !== p; k++) @(posedge pclk);
        if (bit_pos !== p) begin
            bad({24'h0, bit_pos}, {24'h0, p});
            finish_test;
        end
    endtask
    task frame(input logic [7:0] m);
        sq.push_back({1'b1, m});
        sq.push_back(9'h180);
        sq.push_back({1'b1, pat(4'h3, 4'h5)});
        sq.push_back({1'b1, pat(4'h3, 4'h5)});
        sq.push_back(9'h000);
        sq.push_back({1'b1, pat(4'h4, 4'h9)});
        wait_pos(8'h00);
        watch <= 1;
        wait_pos(8'hFF);
        watch <= 0;
        if (sq.size() != 0) bad(sq.size(), 32'h0);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) cmp_rd(rq.pop_front(), pslverr, prdata);
    end
    always @(posedge pclk) begin
        if (phase == 5'h08) begin
            for (int i = 0; i < 6; i++) begin
                if (bit_pos[7:3] == CH[i]) begin
                    sh[i] = {sh[i][6:0], ST[i] == 8 ? control_serial_out : serial_out[ST[i]]};
                    ok[i] = (bit_pos[2:0] == 3'h0 || ok[i]) && (ST[i] == 8 || serial_oe[ST[i]]);
                    if (bit_pos[2:0] == 3'h7 && watch) cmp_byte(sq.pop_front(), {ok[i], sh[i]});
                end
            end
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, `TSW_OFF_CTRL, 32'h0, 32'h0, 32'hFF, 0);
        apb(0, `TSW_OFF_PAIRS, 32'h0, 32'h32, 32'hFF, 0);
        for (int i = 0; i < 16; i++) begin
            apb(1, `TSW_OFF_MODE, i, 32'h0, 32'h0, 0);
            apb(0, `TSW_OFF_MODE, 32'h0, i, 32'hF, 0);
        end
        apb(1, `TSW_OFF_PAIRS, 32'h54, 32'h0, 32'h0, 0);
        apb(0, `TSW_OFF_PAIRS, 32'h0, 32'h54, 32'hFF, 0);
        apb(1, `TSW_OFF_MODE, 32'h0, 32'h0, 32'h0, 0);
        apb(0, 12'h010, 32'h0, 32'h0, 32'hFFFFFFFF, 1);
        apb(1, 12'h010, 32'h0, 32'h0, 32'h0, 1);
        repeat (1100) @(posedge pclk);
        apb(0, `TSW_OFF_STATUS, 32'h0, 32'hA, 32'hB, 0);
        rnd = lfsr(rnd);
        msg = rnd[7:0];
        mem(1, `TSW_AREA_CMH, 9'h001, 8'h0D);
        mem(1, `TSW_AREA_CML, 9'h001, msg);
        mem(1, `TSW_AREA_CMH, 9'h022, 8'h04);
        mem(1, `TSW_AREA_CML, 9'h022, 8'h65);
        mem(1, `TSW_AREA_CMH, 9'h042, 8'h04);
        mem(1, `TSW_AREA_CML, 9'h042, 8'h65);
        mem(1, `TSW_AREA_CMH, 9'h064, 8'h06);
        mem(1, `TSW_AREA_CML, 9'h064, 8'h89);
        wait_pos(8'h00);
        frame(msg);
        frame(msg);
        rnd = lfsr(rnd);
        msg = rnd[7:0];
        mem(1, `TSW_AREA_CML, 9'h001, msg);
        frame(msg);
        mem(0, `TSW_AREA_DM, 9'h065, pat(4'h3, 4'h5));
        mem(0, `TSW_AREA_CMH, 9'h001, 8'h0D);
        mem(0, `TSW_AREA_CML, 9'h001, msg);
        apb(0, `TSW_OFF_STATUS, 32'h0, 32'hE, 32'hF, 0);
        // gate inside channel 1, where stream 0 is enabled, so the override is visible
        wait_pos(8'h0A);
        global_output_drive_gate <= 0;
        repeat (40) @(posedge pclk);
        cmp_byte(9'h000, {serial_oe[0], 8'h00});
        global_output_drive_gate <= 1;
        host_bus_select_pin <= 0;
        repeat (2) @(posedge pclk);
        cmp_byte(9'h100, {serial_oe[0], 8'h00});
        apb(0, `TSW_OFF_STATUS, 32'h0, 32'hC, 32'hE, 0);
        repeat (4) @(posedge pclk);
        finish_test;
    end
endmodule
`default_nettype wire
